/* File: rtl/adc_input_reference_config.sv */
`timescale 1ns/1ps
`include "adc_cfg_consts.svh"

// Function
// - align 0 puts result 11..4 high; align 1 puts 11..8 high, 7..0 low.
// - align 0 puts low nibble in low byte top; unused result bits read zero.
// - channel codes 0 to 11 connect external input of that number.
// - channel code 12 connects input twelve; codes 13 to 15 connect nothing.
// - external channel routed only for source codes 0000, 0100 and 11xx.
// - source codes 1..3 pick supply fractions, 5..7 pick amplifier output fractions.
// - source codes 1000 to 1011 are reserved and tie the input to ground.
// - any internal source disconnects every external channel.
// - conversion clock is system clock divided by two to the select value.
// - unimplemented register bits read as zero, except format/channel bits 7..5, which read coreCtrlIn.
// - amplifier input from reference input pin at 0, bandgap at 1 disconnecting pin.
// - reference select 00 supply, 01 reference pin, 1x amplifier output.
// - supply or amplifier reference disconnects the reference input pin.
// - gain select drives amplifier gain: 1, 1.667, 2.5, 3.333.
// - bandgap enable powers the bandgap circuit.
module adc_input_reference_config
	import adc_cfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// conversion core side
	input wire logic [11:0] convResult,
	input wire logic [2:0] coreCtrlIn,
	output logic [2:0] coreCtrlOut,
	output logic convTick,
	// input multiplexer
	output logic [12:0] channelConnect,
	output logic [7:0] sourceSelect,
	// amplifier and reference
	output logic pgaEnable,
	output logic pgaFromPin,
	output logic pgaFromBandgap,
	output logic [1:0] pgaGain,
	output logic refFromSupply,
	output logic refFromPin,
	output logic refFromPga,
	output logic bandgapEnable
);
	logic [7:0] fmtCh_reg;
	logic [7:0] fmtCh_next;
	logic [7:0] srcClk_reg;
	logic [7:0] srcClk_next;
	logic [7:0] ampRef_reg;
	logic [7:0] ampRef_next;
	logic [7:0] bg_reg;
	logic [7:0] bg_next;
	logic [7:0] rd_reg;
	logic [7:0] rd_next;
	logic [12:0] chan_reg;
	logic [12:0] chan_next;
	logic [7:0] src_reg;
	logic [7:0] src_next;
	logic [8:0] amp_reg;
	logic [8:0] amp_next;
	logic tick;
	source_e srcKind;
	ref_e refKind;

	// classify the four-bit source code
	function automatic source_e decode_source(input logic [3:0] code);
		case (code)
			4'h0, 4'h4, 4'hc, 4'hd, 4'he, 4'hf: decode_source = SRC_EXTERNAL;
			4'h1: decode_source = SRC_AVDD;
			4'h2: decode_source = SRC_AVDD_HALF;
			4'h3: decode_source = SRC_AVDD_QUARTER;
			4'h5: decode_source = SRC_PGA;
			4'h6: decode_source = SRC_PGA_HALF;
			4'h7: decode_source = SRC_PGA_QUARTER;
			default: decode_source = SRC_GROUND;
		endcase
	endfunction

	// classify the reference code
	function automatic ref_e decode_ref(input logic [1:0] code);
		case (code)
			2'h0: decode_ref = REF_AVDD;
			2'h1: decode_ref = REF_PIN;
			default: decode_ref = REF_PGA;
		endcase
	endfunction

	// result byte formatting, shared by both read offsets
	function automatic logic [15:0] format_result(input logic align, input logic [11:0] d);
		if (align) begin
			format_result = {4'h0, d};
		end else begin
			format_result = {d, 4'h0};
		end
	endfunction

	// register writes; masks keep unimplemented bits at zero
	always_comb begin
		fmtCh_next = fmtCh_reg;
		srcClk_next = srcClk_reg;
		ampRef_next = ampRef_reg;
		bg_next = bg_reg;
		if (regWrite) begin
			case (regAddr)
				`OFS_FORMAT_CHANNEL: fmtCh_next = regWrData & `MASK_FORMAT_CHANNEL;
				`OFS_SOURCE_CLOCK: srcClk_next = regWrData & `MASK_SOURCE_CLOCK;
				`OFS_AMP_REFERENCE: ampRef_next = regWrData & `MASK_AMP_REFERENCE;
				`OFS_BANDGAP: bg_next = regWrData & `MASK_BANDGAP;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fmtCh_reg <= `RST_FORMAT_CHANNEL;
			srcClk_reg <= `RST_SOURCE_CLOCK;
			ampRef_reg <= `RST_AMP_REFERENCE;
			bg_reg <= `RST_BANDGAP;
		end else begin
			fmtCh_reg <= fmtCh_next;
			srcClk_reg <= srcClk_next;
			ampRef_reg <= ampRef_next;
			bg_reg <= bg_next;
		end
	end

	// read mux; data valid the cycle after the strobe, zero otherwise
	always_comb begin
		logic [15:0] res;
		res = format_result(fmtCh_reg[`POS_ALIGN], convResult);
		rd_next = 8'h00;
		if (regRead) begin
			case (regAddr)
				`OFS_FORMAT_CHANNEL: rd_next = {coreCtrlIn, fmtCh_reg[4:0]};
				`OFS_SOURCE_CLOCK: rd_next = srcClk_reg;
				`OFS_AMP_REFERENCE: rd_next = ampRef_reg;
				`OFS_BANDGAP: rd_next = bg_reg;
				`OFS_RESULT_HIGH: rd_next = res[15:8];
				`OFS_RESULT_LOW: rd_next = res[7:0];
				default: rd_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_reg <= 8'h00;
		end else begin
			rd_reg <= rd_next;
		end
	end

	// input path steering; internal sources always break external channels
	always_comb begin
		srcKind = decode_source(srcClk_reg[7:`POS_SRC_LO]);
		chan_next = 13'h0000;
		src_next = 8'h00;
		if (srcKind == SRC_EXTERNAL) begin
			if (fmtCh_reg[3:0] <= `LAST_CHANNEL) begin
				chan_next = 13'(14'h0001 << fmtCh_reg[3:0]);
			end
		end
		// chan_next stays zero for every internal source
		src_next = 8'(9'h001 << srcKind);
	end

	// reference and amplifier steering
	always_comb begin
		refKind = decode_ref(ampRef_reg[3:`POS_REF_LO]);
		amp_next[0] = ampRef_reg[`POS_PGA_EN];
		amp_next[1] = ~ampRef_reg[`POS_PGA_IN];
		amp_next[2] = ampRef_reg[`POS_PGA_IN];
		amp_next[4:3] = ampRef_reg[1:0];
		amp_next[5] = (refKind == REF_AVDD);
		amp_next[6] = (refKind == REF_PIN);
		amp_next[7] = (refKind == REF_PGA);
		amp_next[8] = bg_reg[0];
	end

	// analog select lines registered so every output is a flip-flop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_reg <= 13'h0000;
			src_reg <= 8'h00;
			amp_reg <= 9'h000;
		end else begin
			chan_reg <= chan_next;
			src_reg <= src_next;
			amp_reg <= amp_next;
		end
	end

	// conversion clock enable
	conv_clock_prescaler prescaler (
		.clk(clk),
		.resetn(resetn),
		.divSel(srcClk_reg[2:0]),
		.convTick(tick)
	);

	assign convTick = tick;
	assign regRdData = rd_reg;
	assign coreCtrlOut = {fmtCh_reg[7:5]};
	assign channelConnect = chan_reg;
	assign sourceSelect = src_reg;
	assign pgaEnable = amp_reg[0];
	assign pgaFromPin = amp_reg[1];
	assign pgaFromBandgap = amp_reg[2];
	assign pgaGain = amp_reg[4:3];
	assign refFromSupply = amp_reg[5];
	assign refFromPin = amp_reg[6];
	assign refFromPga = amp_reg[7];
	assign bandgapEnable = amp_reg[8];
endmodule

/* File: include/adc_cfg_consts.svh */
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

// register offsets on the plain register port
`define OFS_FORMAT_CHANNEL 3'h0
`define OFS_SOURCE_CLOCK 3'h1
`define OFS_AMP_REFERENCE 3'h2
`define OFS_BANDGAP 3'h3
`define OFS_RESULT_HIGH 3'h4
`define OFS_RESULT_LOW 3'h5

// reset values
`define RST_FORMAT_CHANNEL 8'h00
`define RST_SOURCE_CLOCK 8'h00
`define RST_AMP_REFERENCE 8'h00
`define RST_BANDGAP 8'h00

// writable bit masks; clear bits are unimplemented and read as zero, except format/channel bits 7..5, which read coreCtrlIn
`define MASK_FORMAT_CHANNEL 8'h1f
`define MASK_SOURCE_CLOCK 8'hf7
`define MASK_AMP_REFERENCE 8'h9f
`define MASK_BANDGAP 8'h01

// field positions
`define POS_ALIGN 4
`define POS_SRC_LO 4
`define POS_PGA_EN 7
`define POS_PGA_IN 4
`define POS_REF_LO 2

// highest external channel index
`define LAST_CHANNEL 4'hc

`endif

/* File: include/adc_cfg_pkg.sv */
package adc_cfg_pkg;
	// what the converter input multiplexer is tied to
	typedef enum {
		SRC_EXTERNAL,
		SRC_AVDD,
		SRC_AVDD_HALF,
		SRC_AVDD_QUARTER,
		SRC_PGA,
		SRC_PGA_HALF,
		SRC_PGA_QUARTER,
		SRC_GROUND
	} source_e;
	// reference path choice
	typedef enum {
		REF_AVDD,
		REF_PIN,
		REF_PGA
	} ref_e;
endpackage

/* File: rtl/conv_clock_prescaler.sv */
`timescale 1ns/1ps
`include "adc_cfg_consts.svh"

// free-running divider, one-cycle tick every 2**divSel clocks
module conv_clock_prescaler (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// divide select
	input wire logic [2:0] divSel,
	// conversion clock enable
	output logic convTick
);
	logic [6:0] count_reg;
	logic [6:0] count_next;
	logic tick_reg;
	logic tick_next;
	logic [6:0] limit;

	// terminal count 2**n - 1; code 0 ticks every cycle
	always_comb begin
		limit = 7'(({7'h0, 1'b1} << divSel) - 8'h01);
		if (count_reg >= limit) begin
			count_next = 7'h00;
			tick_next = 1'b1;
		end else begin
			count_next = count_reg + 7'h01;
			tick_next = 1'b0;
		end
	end

	// counter keeps running; a new select takes effect at once, wrapping on the next clock if the count is already past it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= 7'h00;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end

	assign convTick = tick_reg;
endmodule

/* File: tb/adc_input_reference_config_assertions.sv */
`timescale 1ns/1ps
// watches register writes and the decoded selects they produce
module adc_cfg_checker
	import adc_cfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// decoded selects
	input wire logic [12:0] channelConnect,
	input wire logic [7:0] sourceSelect,
	input wire logic pgaFromPin,
	input wire logic pgaFromBandgap,
	input wire logic [1:0] pgaGain,
	input wire logic refFromPin,
	input wire logic refFromPga,
	input wire logic bandgapEnable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// decoded selects land one edge after the write edge, so checks sample them two edges on
	ext_isolated_a: assert property (!sourceSelect[0] |-> channelConnect == 13'h0)
		else $error("pin joined to internal source");
	src_single_a: assert property ($onehot0(sourceSelect))
		else $error("several sources at once");
	reserved_ground_a: assert property (regWrite && regAddr == 3'h1 && regWrData[7:6] == 2'b10
		|=> ##1 sourceSelect == 8'h80) else $error("reserved code not grounded");
	ref_pga_a: assert property (regWrite && regAddr == 3'h2 && regWrData[3]
		|=> ##1 refFromPga && !refFromPin) else $error("pga reference wrong");
	pga_bandgap_a: assert property (regWrite && regAddr == 3'h2 && regWrData[4]
		|=> ##1 pgaFromBandgap && !pgaFromPin) else $error("pga input wrong");
	gain_follow_a: assert property (regWrite && regAddr == 3'h2
		|=> ##1 pgaGain == $past(regWrData[1:0], 2)) else $error("gain wrong");
	bandgap_follow_a: assert property (regWrite && regAddr == 3'h3
		|=> ##1 bandgapEnable == $past(regWrData[0], 2)) else $error("bandgap wrong");
	unused_zero_a: assert property (regRead && regAddr == 3'h3 |=> regRdData[7:1] == 7'h00)
		else $error("unimplemented bits set");
	idle_read_a: assert property (!regRead |=> regRdData == 8'h00)
		else $error("read data outside its cycle");
endmodule
bind adc_input_reference_config adc_cfg_checker i_chk (.clk, .resetn, .regAddr, .regWrData,
	.regWrite, .regRead, .regRdData, .channelConnect, .sourceSelect, .pgaFromPin,
	.pgaFromBandgap, .pgaGain, .refFromPin, .refFromPga, .bandgapEnable);

/* File: tb/analog_core_model.sv */
`timescale 1ns/1ps
// stand-in for the converter core: holds a result, counts conversion ticks
module analog_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// from the block
	input wire logic convTick,
	input wire logic [2:0] coreCtrlOut,
	// bench side
	input wire logic [11:0] level,
	output logic [11:0] convResult,
	output logic [2:0] coreCtrlIn,
	output int tickCount
);
	// status idle: start and busy sequencing is outside this block
	assign coreCtrlIn = 3'b000;
	// result lags the level one clock, like the core's holding register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			convResult <= 12'h000;
			tickCount <= 0;
		end else begin
			convResult <= level;
			if (convTick) tickCount <= tickCount + 1;
		end
	end
endmodule

/* File: tb/adc_input_reference_config_test.sv */
`timescale 1ns/1ps
`include "adc_cfg_consts.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module adc_input_reference_config_test;
	logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [2:0] regAddr = 3'h0, coreCtrlIn, coreCtrlOut;
	logic [7:0] regWrData = 8'h00, regRdData, sourceSelect;
	logic [11:0] level = 12'h000, convResult;
	logic [12:0] channelConnect;
	logic convTick, pgaEnable, pgaFromPin, pgaFromBandgap, refFromSupply, refFromPin, refFromPga;
	logic bandgapEnable;
	logic [1:0] pgaGain;
	logic [7:0] msk [4] = '{`MASK_FORMAT_CHANNEL, `MASK_SOURCE_CLOCK, `MASK_AMP_REFERENCE, `MASK_BANDGAP};
	int errors = 0, checked = 0, tickCount, t0;
	adc_input_reference_config i_dut (.clk, .resetn, .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData, .convResult, .coreCtrlIn, .coreCtrlOut, .convTick, .channelConnect,
		.sourceSelect, .pgaEnable, .pgaFromPin, .pgaFromBandgap, .pgaGain, .refFromSupply,
		.refFromPin, .refFromPga, .bandgapEnable);
	analog_core_model i_core (.clk, .resetn, .convTick, .coreCtrlOut, .level, .convResult,
		.coreCtrlIn, .tickCount);
	// bus cycles; strobes drop after the sampling edge so tasks chain safely
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		`CHK(regRdData, e)
	endtask
	// decoded selects need one more edge after the register updates
	task automatic settle;
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic t_regs;
		for (int i = 3; i >= 0; i--) rd_chk(3'(i), 8'h00);
		for (int i = 7; i >= 0; i--) wr(3'(i), 8'hff);
		`CHK(coreCtrlOut, 3'h0)
		for (int i = 0; i < 4; i++) rd_chk(3'(i), msk[i]);
		rd_chk(3'h7, 8'h00);
		for (int i = 0; i < 4; i++) wr(3'(i), 8'h00);
	endtask
	task automatic t_align;
		@(posedge clk);
		level <= 12'habc;
		rd_chk(`OFS_RESULT_HIGH, 8'hab);
		rd_chk(`OFS_RESULT_LOW, 8'hc0);
		wr(`OFS_FORMAT_CHANNEL, 8'h10);
		rd_chk(`OFS_RESULT_HIGH, 8'h0a);
		rd_chk(`OFS_RESULT_LOW, 8'hbc);
	endtask
	task automatic t_source;
		logic [7:0] es;
		// amplifier on, since some source codes pick its output
		wr(`OFS_AMP_REFERENCE, 8'h80);
		for (int c = 0; c < 16; c++) begin
			wr(`OFS_SOURCE_CLOCK, 8'(c << 4));
			es = (c == 0 || c == 4 || c > 11) ? 8'h01 : (c < 4) ? 8'(1 << c) :
				(c < 8) ? 8'(1 << (c - 1)) : 8'h80;
			for (int n = 0; n < 16; n++) begin
				wr(`OFS_FORMAT_CHANNEL, 8'(n));
				settle();
				`CHK(sourceSelect, es)
				`CHK(channelConnect, (es[0] && n <= `LAST_CHANNEL) ? 13'(1 << n) : 13'h0)
			end
		end
	endtask
	task automatic t_amp;
		logic [5:0] v;
		wr(`OFS_BANDGAP, 8'h01);
		// reference pins taken as already freed of their other functions
		for (int i = 0; i < 64; i++) begin
			v = 6'(i);
			v[5] = v[5] | v[3];
			wr(`OFS_AMP_REFERENCE, {v[5], 2'b00, v[4:0]});
			settle();
			`CHK({pgaEnable, pgaFromPin, pgaFromBandgap, pgaGain}, {v[5], !v[4], v[4], v[1:0]})
			`CHK({refFromSupply, refFromPin, refFromPga}, {v[3:2] == 2'h0, v[3:2] == 2'h1, v[3]})
		end
		for (int b = 1; b >= 0; b--) begin
			wr(`OFS_BANDGAP, 8'(b));
			settle();
			`CHK(bandgapEnable, 1'(b))
		end
	endtask
	// the counter may sit past a new wrap point, so let it come round first
	task automatic t_clock;
		for (int s = 0; s < 8; s++) begin
			wr(`OFS_SOURCE_CLOCK, 8'(s));
			repeat (256) @(posedge clk);
			t0 = tickCount;
			repeat (4 << s) @(posedge clk);
			`CHK(tickCount - t0, 4)
		end
	endtask
	task automatic give_verdict;
		if (errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		t_align();
		t_source();
		t_amp();
		t_clock();
		give_verdict();
	end
	// the full sequence needs well under 10000 clocks
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule
